// *** include/sisen_pkg.sv ***
// Purpose: shared constants and types of the sensor interrupt status block
// Assumes: one 100 MHz system clock
// Notes:   offsets are byte register addresses of the serial register port
package sisen_pkg;

	// ****************************************
	// register map
	// ****************************************
	localparam logic [7:0] SISEN_OFF_STATUS1 = 8'h00;
	localparam logic [7:0] SISEN_OFF_STATUS2 = 8'h01;
	localparam logic [7:0] SISEN_OFF_ENABLE1 = 8'h02;
	localparam logic [7:0] SISEN_RST_STATUS1 = 8'h00;
	localparam logic [7:0] SISEN_RST_STATUS2 = 8'h00;
	localparam logic [7:0] SISEN_RST_ENABLE1 = 8'h00;
	localparam logic [7:0] SISEN_EN1_WMASK   = 8'hFE;

	// ****************************************
	// field positions, status 1, enable 1 and status 2
	// ****************************************
	localparam int SISEN_B_AFULL   = 7;
	localparam int SISEN_B_DRDY    = 6;
	localparam int SISEN_B_ALC     = 5;
	localparam int SISEN_B_PROX    = 4;
	localparam int SISEN_B_LEDNC   = 3;
	localparam int SISEN_B_TEMP    = 2;
	localparam int SISEN_B_SUPPLY  = 1;
	localparam int SISEN_B_PWR     = 0;
	localparam int SISEN_B_HASH    = 0;

	// ****************************************
	// timing and proximity
	// ****************************************
	localparam int SISEN_CLK_MHZ        = 100;
	localparam int SISEN_SUPPLY_QUAL_MS = 10;
	localparam int SISEN_SUPPLY_QUAL_CYC =
		SISEN_SUPPLY_QUAL_MS * 1000 * SISEN_CLK_MHZ;
	localparam int SISEN_PROX_SHIFT     = 11;
	localparam logic [3:0] SISEN_RATE_PILOT_8HZ = 4'hF;

	// ****************************************
	// types
	// ****************************************
	typedef enum logic {SISEN_MODE_NORMAL, SISEN_MODE_PROX} sisen_mode_t;

	typedef struct packed {
		logic afull;
		logic data_rdy;
		logic ambient_ovf;
		logic led_nc;
		logic temp_done;
		logic uvlo;
		logic hash_done;
	} sisen_evt_t;

	typedef struct packed {
		logic       rd;
		logic       wr;
		logic [7:0] addr;
		logic [7:0] wdata;
	} sisen_req_t;

endpackage

// *** rtl/sisen_supply_qual.sv ***
// Purpose: qualifies the digital supply out-of-range level over a delay
// Assumes: monitor level synchronous to the clock
// Notes:   output stays high while the condition persists after qualifying
`timescale 1ns/1ns
module sisen_supply_qual
	import sisen_pkg::*;
#(
	parameter int QUAL_CYC = SISEN_SUPPLY_QUAL_CYC
) (
	// clock and reset
	input  wire logic i_ref_clk,
	input  wire logic i_rst_n,
	input  wire logic i_clk_en,
	// monitor
	input  wire logic i_out_of_range,
	output logic      o_qualified
);

	localparam int CW = $clog2(QUAL_CYC + 1);
	localparam logic [CW-1:0] CNT_MAX = CW'(QUAL_CYC);

	logic [CW-1:0] cnt_q;
	logic [CW-1:0] cnt_d;

	// a glitch shorter than the delay restarts the count
	always_comb begin
		cnt_d = '0;
		if (i_out_of_range) begin
			cnt_d = (cnt_q == CNT_MAX) ? cnt_q : cnt_q + 1'b1; // see RL6
		end
	end

	always_ff @(posedge i_ref_clk) begin
		if (!i_rst_n) begin
			cnt_q <= '0;
		end else if (i_clk_en) begin
			cnt_q <= cnt_d;
		end
	end

	assign o_qualified = i_out_of_range && (cnt_q == CNT_MAX); // see RL6

	qual_needs_level_a: assert property ( // see RL6
		@(posedge i_ref_clk) disable iff (!i_rst_n)
		o_qualified |-> i_out_of_range && $past(i_out_of_range))
		else $error("supply qualified without a lasting condition");

endmodule // sisen_supply_qual

// *** rtl/sisen_core.sv ***
// Purpose: interrupt flags, enables and proximity mode of the sensor front
// Assumes: register port comes from the serial interface, one clock
// Notes:   read data is registered one cycle after the read strobe
// Contract
// RL1: at sample end, a noncompliant LED driver sets its flag when enabled
// RL2: LED noncompliance flag is read-only and clears on status read
// RL3: temperature-ready flag sets when a temperature conversion completes
// RL4: temperature-ready clears on temperature result read or status 1 read
// RL5: supply-range flag sets when digital supply is out of window
// RL6: supply detection waits 10 ms and keeps re-setting while out of range
// RL7: supply-range flag is read-only and clears on status 1 read
// RL8: power-ready flag sets on analog undervoltage, never on soft reset
// RL9: power-ready clears on status 1 read or shutdown bit written 1
// RL10: hash-done flag, bit 0 at 0x01, sets when authentication finishes
// RL11: hash-done flag is read-only and clears when its register is read
// RL12: enable register 0x02, bits 7..1 read/write, reset 0, 1 enables
// RL13: proximity mode when first-slot reading is below 2048 times threshold
// RL14: proximity mode samples at 8 Hz, single pilot exposure, pilot current
// RL15: normal mode uses selected sample rate and full programmed sequence
// RL16: with proximity enabled, each mode entry sets the proximity flag
// RL17: proximity disabled forces normal mode, no flag, sequence runs directly
// RL18: status 1 at 0x00 holds eight read-only flags, reset zero
// RL19: almost-full clears on status 1 read or data read when option set
// RL20: ambient overflow sets at cancellation limit, clears on status 1 read
// RL21: interrupt output active while any enabled flag is set
// RL22: host reads status after interrupt, which clears the flags
`timescale 1ns/1ns
module sisen_core
	import sisen_pkg::*;
#(
	parameter int ADC_W    = 19,
	parameter int THR_W    = 8,
	parameter int QUAL_CYC = SISEN_SUPPLY_QUAL_CYC
) (
	// clock and reset
	input  wire logic             i_ref_clk,
	input  wire logic             i_rst_n,
	input  wire logic             i_clk_en,
	// register port
	input  wire sisen_req_t       i_req,
	output logic [7:0]            o_reg_rdata,
	// events from the front end
	input  wire sisen_evt_t       i_evt,
	input  wire logic             i_sample_end,
	input  wire logic             i_soft_reset,
	input  wire logic             i_vdd_out_of_range,
	// side effects of other registers
	input  wire logic             i_temp_result_rd,
	input  wire logic             i_fifo_data_rd,
	input  wire logic             i_clear_on_data_read,
	input  wire logic             i_shutdown_control_wr1,
	// proximity detection
	input  wire logic             i_first_slot_valid,
	input  wire logic [ADC_W-1:0] i_first_slot_data,
	input  wire logic [THR_W-1:0] i_proximity_threshold,
	input  wire logic [3:0]       i_sample_rate_select,
	// outputs
	output logic                  o_irq,
	output logic                  o_prox_mode,
	output logic                  o_pilot_exposure,
	output logic [3:0]            o_rate_sel
);

	localparam int CMP_W = ADC_W + THR_W + SISEN_PROX_SHIFT;

	// ****************************************
	// state
	// ****************************************
	logic [7:0]  stat1_q, stat1_d;
	logic        hash_q, hash_d;
	logic [7:0]  en1_q, en1_d;
	logic [7:0]  rdata_q, rdata_d;
	logic        irq_q, irq_d;
	sisen_mode_t mode_q, mode_d;
	logic [3:0]  rate_q, rate_d;
	logic        prox_q, prox_d;
	logic        pilot_q, pilot_d;
	logic        supply_qual;
	logic        rd_s1, rd_s2, wr_en1;
	logic        data_clr;
	logic        prox_evt;
	logic        below;
	logic [7:0]  set1, clr1;

	sisen_supply_qual #(
		.QUAL_CYC (QUAL_CYC)
	) u_qual (
		.i_ref_clk      (i_ref_clk),
		.i_rst_n        (i_rst_n),
		.i_clk_en       (i_clk_en),
		.i_out_of_range (i_vdd_out_of_range),
		.o_qualified    (supply_qual)
	);

	// ****************************************
	// decode and proximity compare
	// ****************************************
	assign rd_s1  = i_req.rd && (i_req.addr == SISEN_OFF_STATUS1);
	assign rd_s2  = i_req.rd && (i_req.addr == SISEN_OFF_STATUS2);
	assign wr_en1 = i_req.wr && (i_req.addr == SISEN_OFF_ENABLE1);
	assign data_clr = i_fifo_data_rd && i_clear_on_data_read; // see RL19
	// threshold scaled by 2048, compared at a common width
	assign below = CMP_W'(i_first_slot_data) <
		CMP_W'({i_proximity_threshold, {SISEN_PROX_SHIFT{1'b0}}}); // see RL13

	// ****************************************
	// proximity mode
	// ****************************************
	always_comb begin
		mode_d   = mode_q;
		prox_evt = 1'b0;
		if (!en1_q[SISEN_B_PROX]) begin
			mode_d = SISEN_MODE_NORMAL; // see RL17
		end else if (i_first_slot_valid) begin
			mode_d = below ? SISEN_MODE_PROX : SISEN_MODE_NORMAL; // see RL13
			prox_evt = (mode_d != mode_q); // see RL16
		end
		case (mode_d)
			SISEN_MODE_PROX:   rate_d = SISEN_RATE_PILOT_8HZ; // see RL14
			SISEN_MODE_NORMAL: rate_d = i_sample_rate_select; // see RL15
			default:           rate_d = i_sample_rate_select;
		endcase
		// mode outputs come from their own flops, not from a compare
		prox_d  = (mode_d == SISEN_MODE_PROX); // see RL13
		pilot_d = (mode_d == SISEN_MODE_PROX); // see RL14
	end

	// ****************************************
	// flags, enables, read data
	// ****************************************
	always_comb begin
		set1 = '0;
		clr1 = '0;
		set1[SISEN_B_AFULL]  = i_evt.afull;
		set1[SISEN_B_DRDY]   = i_evt.data_rdy;
		set1[SISEN_B_ALC]    = i_evt.ambient_ovf; // see RL20
		set1[SISEN_B_PROX]   = prox_evt; // see RL16
		set1[SISEN_B_LEDNC]  = i_sample_end && i_evt.led_nc
			&& en1_q[SISEN_B_LEDNC]; // see RL1
		set1[SISEN_B_TEMP]   = i_evt.temp_done; // see RL3
		set1[SISEN_B_SUPPLY] = supply_qual; // see RL5
		// soft reset is not an undervoltage
		set1[SISEN_B_PWR]    = i_evt.uvlo && !i_soft_reset; // see RL8
		if (rd_s1) begin // see RL7
			clr1 = 8'hFF; // see RL18
		end
		clr1[SISEN_B_AFULL] = clr1[SISEN_B_AFULL] || data_clr; // see RL19
		clr1[SISEN_B_DRDY]  = clr1[SISEN_B_DRDY] || data_clr;
		clr1[SISEN_B_TEMP]  = clr1[SISEN_B_TEMP] || i_temp_result_rd; // see RL4
		clr1[SISEN_B_PWR]   = clr1[SISEN_B_PWR]
			|| i_shutdown_control_wr1; // see RL9
		// an event in the clearing cycle survives the clear
		stat1_d = (stat1_q & ~clr1) | set1; // see RL2
		hash_d  = (hash_q && !rd_s2) || i_evt.hash_done; // see RL10
		en1_d   = wr_en1 ? (i_req.wdata & SISEN_EN1_WMASK) : en1_q; // see RL12
		rdata_d = rdata_q;
		if (i_req.rd) begin
			case (i_req.addr)
				SISEN_OFF_STATUS1: rdata_d = stat1_q;
				SISEN_OFF_STATUS2: rdata_d = {7'h00, hash_q}; // see RL11
				SISEN_OFF_ENABLE1: rdata_d = en1_q;
				default:           rdata_d = 8'h00;
			endcase
		end
		// power-ready has no enable bit and never raises the output
		irq_d = |(stat1_d & en1_d); // see RL21
	end

	always_ff @(posedge i_ref_clk) begin
		if (!i_rst_n) begin
			stat1_q <= SISEN_RST_STATUS1;
			hash_q  <= SISEN_RST_STATUS2[SISEN_B_HASH];
			en1_q   <= SISEN_RST_ENABLE1;
			rdata_q <= 8'h00;
			irq_q   <= 1'b0;
			mode_q  <= SISEN_MODE_NORMAL;
			rate_q  <= 4'h0;
			prox_q  <= 1'b0;
			pilot_q <= 1'b0;
		end else if (i_clk_en) begin
			stat1_q <= stat1_d;
			hash_q  <= hash_d;
			en1_q   <= en1_d;
			rdata_q <= rdata_d;
			irq_q   <= irq_d;
			mode_q  <= mode_d;
			rate_q  <= rate_d;
			prox_q  <= prox_d;
			pilot_q <= pilot_d;
		end
	end

	assign o_reg_rdata      = rdata_q;
	assign o_irq            = irq_q;
	assign o_prox_mode      = prox_q;
	assign o_pilot_exposure = pilot_q; // see RL14
	assign o_rate_sel       = rate_q;

	// ****************************************
	// checks
	// ****************************************
	default clocking cb @(posedge i_ref_clk); endclocking
	default disable iff (!i_rst_n);

	led_flag_set_a: assert property ( // see RL1
		i_clk_en && i_sample_end && i_evt.led_nc && en1_q[SISEN_B_LEDNC]
		|=> stat1_q[SISEN_B_LEDNC])
		else $error("led noncompliance not flagged");

	led_flag_clr_a: assert property ( // see RL2
		i_clk_en && rd_s1 && !i_sample_end |=> !stat1_q[SISEN_B_LEDNC])
		else $error("led flag survived status read");

	temp_clear_a: assert property ( // see RL4
		i_clk_en && i_temp_result_rd && !i_evt.temp_done
		|=> !stat1_q[SISEN_B_TEMP])
		else $error("temperature flag not cleared");

	supply_reset_a: assert property ( // see RL6
		i_clk_en && supply_qual |=> stat1_q[SISEN_B_SUPPLY])
		else $error("supply flag not re-set");

	pwr_shut_clr_a: assert property ( // see RL9
		i_clk_en && i_shutdown_control_wr1 && !i_evt.uvlo
		|=> !stat1_q[SISEN_B_PWR])
		else $error("power flag not cleared by shutdown");

	pwr_soft_rst_a: assert property ( // see RL8
		i_clk_en && i_soft_reset && !stat1_q[SISEN_B_PWR]
		|=> !stat1_q[SISEN_B_PWR])
		else $error("soft reset set power flag");

	hash_read_a: assert property ( // see RL11
		i_clk_en && rd_s2 && hash_q && !i_evt.hash_done
		|=> !hash_q && rdata_q == 8'h01)
		else $error("hash flag read or clear wrong");

	irq_match_a: assert property ( // see RL21
		o_irq == |(stat1_q & en1_q))
		else $error("interrupt output disagrees with flags");

	prox_off_a: assert property ( // see RL17
		i_clk_en && !en1_q[SISEN_B_PROX] |=> !o_prox_mode ##0
		o_rate_sel == $past(i_sample_rate_select))
		else $error("proximity mode while disabled");

	prox_flag_a: assert property ( // see RL16
		i_clk_en && prox_evt |=> stat1_q[SISEN_B_PROX] && $changed(mode_q))
		else $error("mode entry without proximity flag");

	temp_flag_set_a: assert property ( // see RL3
		i_clk_en && i_evt.temp_done |=> stat1_q[SISEN_B_TEMP])
		else $error("temperature flag not set");

	supply_read_clr_a: assert property ( // see RL7
		i_clk_en && rd_s1 && !supply_qual
		|=> !stat1_q[SISEN_B_SUPPLY])
		else $error("supply flag survived status read");

	pwr_read_clr_a: assert property ( // see RL9
		i_clk_en && rd_s1 && !(i_evt.uvlo && !i_soft_reset)
		|=> !stat1_q[SISEN_B_PWR])
		else $error("power flag survived status read");

	pwr_uvlo_set_a: assert property ( // see RL8
		i_clk_en && i_evt.uvlo && !i_soft_reset
		|=> stat1_q[SISEN_B_PWR])
		else $error("undervoltage not flagged");

	hash_flag_set_a: assert property ( // see RL10
		i_clk_en && i_evt.hash_done |=> hash_q)
		else $error("hash done not flagged");

	enable_write_a: assert property ( // see RL12
		i_clk_en && wr_en1
		|=> en1_q == ($past(i_req.wdata) & SISEN_EN1_WMASK))
		else $error("enable write not applied");

	status_read_a: assert property ( // see RL18
		i_clk_en && rd_s1
		|=> o_reg_rdata == $past(stat1_q))
		else $error("status read data wrong");

	afull_data_clr_a: assert property ( // see RL19
		i_clk_en && data_clr && !i_evt.afull
		|=> !stat1_q[SISEN_B_AFULL])
		else $error("almost-full not cleared by data read");

	ambient_set_a: assert property ( // see RL20
		i_clk_en && i_evt.ambient_ovf |=> stat1_q[SISEN_B_ALC])
		else $error("ambient overflow not flagged");

	led_gated_a: assert property ( // see RL1
		i_clk_en && !en1_q[SISEN_B_LEDNC] && !stat1_q[SISEN_B_LEDNC]
		|=> !stat1_q[SISEN_B_LEDNC])
		else $error("led flag set while disabled");

	prox_entry_a: assert property ( // see RL13
		i_clk_en && en1_q[SISEN_B_PROX] && i_first_slot_valid
		&& below |=> o_prox_mode)
		else $error("proximity mode not entered");

	prox_rate_a: assert property ( // see RL14
		o_prox_mode
		|-> o_pilot_exposure && o_rate_sel == SISEN_RATE_PILOT_8HZ)
		else $error("proximity mode without pilot sampling");

	normal_rate_a: assert property ( // see RL15
		i_clk_en && en1_q[SISEN_B_PROX] && i_first_slot_valid
		&& !below |=> !o_prox_mode ##0
		o_rate_sel == $past(i_sample_rate_select))
		else $error("normal mode rate wrong");

endmodule // sisen_core

// *** verif/sisen_host.sv ***
// Purpose: host model on the register port of the interrupt block
// Assumes: one request at a time, driven just after a rising edge
// Notes:   idle address and data show the inverse of the last value
`timescale 1ns/1ns
module sisen_host
	import sisen_pkg::*;
(
	// clock and read data
	input  wire logic       i_ref_clk,
	input  wire logic [7:0] i_reg_rdata,
	// request
	output sisen_req_t      o_req
);
	initial o_req = '0;

	// read, data taken one cycle after the strobe edge
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge i_ref_clk);
		o_req <= '{1'b1, 1'b0, a, 8'h00};
		@(posedge i_ref_clk);
		o_req <= '{1'b0, 1'b0, ~a, 8'hFF};
		#1 d = i_reg_rdata;
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] w);
		@(posedge i_ref_clk);
		o_req <= '{1'b0, 1'b1, a, w};
		@(posedge i_ref_clk);
		o_req <= '{1'b0, 1'b0, ~a, ~w};
	endtask
endmodule // sisen_host

// *** verif/sisen_core_tb.sv ***
// Purpose: self-checking bench of the interrupt status block
// Assumes: supply qualification shortened to 8 cycles
// Notes:   inputs change on the rising edge by non-blocking assignment
`timescale 1ns/1ns
module sisen_core_tb;
	import sisen_pkg::*;
	localparam int QC = 8;
	logic             clk = 1'b0;
	logic             rst_n = 1'b0;
	sisen_req_t       req;
	sisen_evt_t       evt = '0;
	logic             se = 1'b0, srst = 1'b0, oor = 1'b0, trd = 1'b0;
	logic             frd = 1'b0, opt = 1'b0, sdw = 1'b0, fsv = 1'b0;
	logic             cen = 1'b1;
	logic [18:0]      fsd = '0;
	logic [7:0]       thr = '0, rdata;
	logic [3:0]       rate = 4'h3, rsel;
	logic             irq, prox, pilot;
	int               err_count = 0, compares = 0, cyc = 0;

	always #5 clk = ~clk;

	sisen_core #(.QUAL_CYC(QC)) u_sisen_core (.i_ref_clk(clk),
		.i_rst_n(rst_n), .i_clk_en(cen), .i_req(req),
		.o_reg_rdata(rdata), .i_evt(evt), .i_sample_end(se),
		.i_soft_reset(srst), .i_vdd_out_of_range(oor),
		.i_temp_result_rd(trd), .i_fifo_data_rd(frd),
		.i_clear_on_data_read(opt), .i_shutdown_control_wr1(sdw),
		.i_first_slot_valid(fsv), .i_first_slot_data(fsd),
		.i_proximity_threshold(thr), .i_sample_rate_select(rate),
		.o_irq(irq), .o_prox_mode(prox), .o_pilot_exposure(pilot),
		.o_rate_sel(rsel));
	sisen_host u_sisen_host (.i_ref_clk(clk), .i_reg_rdata(rdata),
		.o_req(req));

	// ****************************************
	// helpers
	// ****************************************
	task automatic stop_test();
		if (err_count == 0 && compares > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	task automatic check(input logic [7:0] got, input logic [7:0] exp);
		compares++;
		if (got !== exp) begin
			err_count++;
			$display("ERROR t=%0t got=%0h exp=%0h", $time, got, exp);
		end
	endtask

	task automatic rs(input logic [7:0] a, input logic [7:0] e);
		logic [7:0] d;
		u_sisen_host.rd(a, d);
		check(d, e);
	endtask

	// event pulse, optionally with the sample end strobe
	task automatic ev(input sisen_evt_t v, input logic s);
		@(posedge clk);
		evt <= v;
		se <= s;
		@(posedge clk);
		evt <= '0;
		se <= 1'b0;
	endtask

	task automatic fs(input logic [18:0] v);
		@(posedge clk);
		fsd <= v;
		fsv <= 1'b1;
		@(posedge clk);
		fsv <= 1'b0;
		@(posedge clk);
		#1;
	endtask

	// ****************************************
	// scenarios
	// ****************************************
	task automatic t_regs();
		rs(8'h00, 8'h00);
		rs(8'h01, 8'h00);
		rs(8'h02, 8'h00);
		u_sisen_host.wr(8'h00, 8'hFF);
		u_sisen_host.wr(8'h02, 8'hFF);
		rs(8'h02, 8'hFE);
		rs(8'h00, 8'h00);
		rs(8'h07, 8'h00);
		u_sisen_host.wr(8'h02, 8'h04);
	endtask

	task automatic t_temp();
		ev(7'h04, 1'b0);
		#1 check(irq, 1'b1);
		@(posedge clk) trd <= 1'b1;
		@(posedge clk) trd <= 1'b0;
		#1 check(irq, 1'b0);
		ev(7'h04, 1'b0);
		rs(8'h00, 8'h04);
		rs(8'h00, 8'h00);
	endtask

	task automatic t_led();
		u_sisen_host.wr(8'h02, 8'h08);
		ev(7'h08, 1'b0);
		rs(8'h00, 8'h00);
		ev(7'h08, 1'b1);
		rs(8'h00, 8'h08);
		rs(8'h00, 8'h00);
		u_sisen_host.wr(8'h02, 8'h00);
		ev(7'h08, 1'b1);
		rs(8'h00, 8'h00);
	endtask

	task automatic t_pwr_hash();
		@(posedge clk) srst <= 1'b1;
		ev(7'h02, 1'b0);
		@(posedge clk) srst <= 1'b0;
		rs(8'h00, 8'h00);
		ev(7'h02, 1'b0);
		@(posedge clk) sdw <= 1'b1;
		@(posedge clk) sdw <= 1'b0;
		rs(8'h00, 8'h00);
		ev(7'h03, 1'b0);
		rs(8'h00, 8'h01);
		rs(8'h00, 8'h00);
		rs(8'h01, 8'h01);
		rs(8'h01, 8'h00);
	endtask

	task automatic t_supply();
		u_sisen_host.wr(8'h02, 8'h02);
		@(posedge clk) oor <= 1'b1;
		// one edge short of qualifying
		repeat (QC) @(posedge clk);
		oor <= 1'b0;
		rs(8'h00, 8'h00);
		@(posedge clk) oor <= 1'b1;
		repeat (QC + 3) @(posedge clk);
		rs(8'h00, 8'h02);
		rs(8'h00, 8'h02);
		check(irq, 1'b1);
		@(posedge clk) oor <= 1'b0;
		repeat (3) @(posedge clk);
		rs(8'h00, 8'h02);
		rs(8'h00, 8'h00);
	endtask

	task automatic t_prox();
		@(posedge clk) thr <= 8'h01;
		u_sisen_host.wr(8'h02, 8'h10);
		fs(19'h007FF);
		check(prox, 1'b1);
		check(pilot, 1'b1);
		check(rsel, SISEN_RATE_PILOT_8HZ);
		rs(8'h00, 8'h10);
		fs(19'h00800);
		check(prox, 1'b0);
		check(rsel, rate);
		check(pilot, 1'b0);
		rs(8'h00, 8'h10);
		fs(19'h00000);
		check(prox, 1'b1);
		rs(8'h00, 8'h10);
		u_sisen_host.wr(8'h02, 8'h00);
		fs(19'h00000);
		check(prox, 1'b0);
		check(rsel, rate);
		rs(8'h00, 8'h00);
	endtask

	task automatic t_fifo();
		ev(7'h60, 1'b0);
		@(posedge clk) frd <= 1'b1;
		@(posedge clk) frd <= 1'b0;
		rs(8'h00, 8'hC0);
		@(posedge clk) opt <= 1'b1;
		ev(7'h60, 1'b0);
		@(posedge clk) frd <= 1'b1;
		@(posedge clk) frd <= 1'b0;
		rs(8'h00, 8'h00);
		ev(7'h10, 1'b0);
		rs(8'h00, 8'h20);
		rs(8'h00, 8'h00);
	endtask

	// frozen clock enable, then a reset in mid-run
	task automatic t_hold();
		u_sisen_host.wr(8'h02, 8'h04);
		@(posedge clk) cen <= 1'b0;
		ev(7'h04, 1'b0);
		u_sisen_host.wr(8'h02, 8'h00);
		@(posedge clk) cen <= 1'b1;
		#1 check(irq, 1'b0);
		rs(8'h02, 8'h04);
		rs(8'h00, 8'h00);
		ev(7'h04, 1'b0);
		#1 check(irq, 1'b1);
		@(posedge clk) rst_n <= 1'b0;
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		#1 check(irq, 1'b0);
		rs(8'h00, 8'h00);
		rs(8'h02, 8'h00);
	endtask

	// runaway guard, the full run needs well under 1000 cycles
	always @(posedge clk) begin
		cyc++;
		if (cyc == 5000) begin
			err_count++;
			stop_test();
		end
	end

	initial begin
		repeat (5) @(posedge clk);
		rst_n <= 1'b1;
		t_regs();
		t_temp();
		t_led();
		t_pwr_hash();
		t_supply();
		t_prox();
		t_fifo();
		t_hold();
		stop_test();
	end
endmodule // sisen_core_tb
